// >>> src/cli_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef CLI_REGS_SVH
`define CLI_REGS_SVH
`define CLI_OFS_CTRL 8'h00
`define CLI_OFS_IDLE 8'h04
`define CLI_OFS_START 8'h08
`define CLI_OFS_MAXT 8'h0C
`define CLI_OFS_HARM 8'h10
`define CLI_OFS_STAT 8'h14
`define CLI_OFS_IRQ 8'h18
`define CLI_OFS_MASK 8'h1C
`define CLI_CTRL_EN 0
`define CLI_CTRL_BLK 1
`define CLI_RST_IDLE 16'h0019
`define CLI_RST_START 16'h0100
`define CLI_RST_MAXT 16'h01F4
`define CLI_IDLE_MIN 16'h0003
`define CLI_IDLE_MAX 16'h0080
`define CLI_START_MIN 16'h004D
`define CLI_START_MAX 16'h0A00
`define CLI_MAXT_MIN 16'h0001
`define CLI_MAXT_MAX 16'h7530
`define CLI_HARM_MAX 8'h63
`define CLI_WIN_MS 8
`define CLI_TICK_NS 10000000
`define CLI_CLK_NS 10
`define CLI_EV_CL 0
`define CLI_EV_IR 1
`define CLI_EV_ABORT 2
`define CLI_RESP_OK 2'b00
`define CLI_RESP_ERR 2'b10
`endif

// >>> src/cli_pkg.sv
// Types shared by the cold-load and inrush detector.
package cli_pkg;
   typedef struct packed {
      logic [15:0] fund;
      logic [15:0] harm;
   } cli_phase_t;
   typedef enum logic [1:0] {
      CLI_IDLE, CLI_ARMED, CLI_WINDOW, CLI_ACTIVE
   } cli_state_t;
endpackage : cli_pkg

// >>> src/cli_detector.sv
// Cold-load pickup and magnetising inrush detector with AXI4-Lite registers.
`timescale 1ns/1ps
`include "cli_regs.svh"

module cli_detector
   import cli_pkg::*;
#(
   parameter int TICK_CYCLES = `CLI_TICK_NS / `CLI_CLK_NS
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite register slave.
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Measurement front end, magnitudes in units of In/256.
   input wire cli_phase_t [2:0] meas,
   input wire logic meas_valid,
   // Outputs to output and blocking matrices.
   output logic cold_load_det,
   output logic inrush_det,
   output logic inrush_block,
   output logic irq
);

   // ****************************************************************
   // Register file
   // ****************************************************************
   logic [1:0] ctrl_reg, ctrl_next;
   logic [15:0] idle_reg, idle_next, start_reg, start_next;
   logic [15:0] maxt_reg, maxt_next;
   logic [7:0] harm_reg, harm_next;
   logic [2:0] irq_reg, irq_next, mask_reg, mask_next;
   logic aw_reg, aw_next, w_reg, w_next;
   logic [7:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next;
   logic [3:0] ws_reg, ws_next;
   logic bv_reg, bv_next, berr_reg, berr_next;
   logic rv_reg, rv_next, rerr_reg, rerr_next;
   logic [31:0] rd_reg, rd_next;
   logic [2:0] ev;
   cli_state_t state_reg, state_next;
   logic [31:0] tick_reg, tick_next;
   logic [7:0] win_reg, win_next;
   logic [15:0] act_reg, act_next;
   logic cyc_reg, cyc_next;
   logic blk_reg, blk_next, ir_reg, ir_next;

   assign s_awready = !aw_reg && !bv_reg;
   assign s_wready = !w_reg && !bv_reg;
   assign s_bvalid = bv_reg;
   assign s_bresp = berr_reg ? `CLI_RESP_ERR : `CLI_RESP_OK;
   assign s_arready = !rv_reg;
   assign s_rvalid = rv_reg;
   assign s_rdata = rd_reg;
   assign s_rresp = rerr_reg ? `CLI_RESP_ERR : `CLI_RESP_OK;

   // Clamp keeps settings inside the supported ranges.
   function automatic logic [15:0] clamp(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      if (v < lo) begin
         return lo;
      end
      if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : clamp

   always_comb begin
      logic [15:0] wv;
      logic do_wr;
      wv = wd_reg[15:0];
      do_wr = aw_reg && w_reg && !bv_reg;
      ctrl_next = ctrl_reg;
      idle_next = idle_reg;
      start_next = start_reg;
      maxt_next = maxt_reg;
      harm_next = harm_reg;
      mask_next = mask_reg;
      aw_next = aw_reg || (s_awvalid && s_awready);
      w_next = w_reg || (s_wvalid && s_wready);
      awa_next = (s_awvalid && s_awready) ? s_awaddr : awa_reg;
      wd_next = (s_wvalid && s_wready) ? s_wdata : wd_reg;
      ws_next = (s_wvalid && s_wready) ? s_wstrb : ws_reg;
      bv_next = bv_reg && !s_bready;
      berr_next = berr_reg;
      irq_next = irq_reg;
      if (do_wr) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         berr_next = 1'b0;
         unique case (awa_reg)
            `CLI_OFS_CTRL: if (ws_reg[0]) ctrl_next = wd_reg[1:0];
            `CLI_OFS_IDLE: if (&ws_reg[1:0]) begin
               idle_next = clamp(wv, `CLI_IDLE_MIN, `CLI_IDLE_MAX);
            end
            `CLI_OFS_START: if (&ws_reg[1:0]) begin
               start_next = clamp(wv, `CLI_START_MIN, `CLI_START_MAX);
            end
            `CLI_OFS_MAXT: if (&ws_reg[1:0]) begin
               maxt_next = clamp(wv, `CLI_MAXT_MIN, `CLI_MAXT_MAX);
            end
            `CLI_OFS_HARM: if (ws_reg[0]) begin
               harm_next = (wd_reg[7:0] > `CLI_HARM_MAX) ?
                  `CLI_HARM_MAX : wd_reg[7:0];
            end
            `CLI_OFS_IRQ: if (ws_reg[0]) irq_next = irq_reg & ~wd_reg[2:0];
            `CLI_OFS_MASK: if (ws_reg[0]) mask_next = wd_reg[2:0];
            `CLI_OFS_STAT: ;
            default: berr_next = 1'b1;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      irq_next = irq_next | ev;
      rv_next = rv_reg && !s_rready;
      rd_next = rd_reg;
      rerr_next = rerr_reg;
      if (s_arvalid && s_arready) begin
         rv_next = 1'b1;
         rerr_next = 1'b0;
         rd_next = 32'h0000_0000;
         unique case (s_araddr)
            `CLI_OFS_CTRL: rd_next[1:0] = ctrl_reg;
            `CLI_OFS_IDLE: rd_next[15:0] = idle_reg;
            `CLI_OFS_START: rd_next[15:0] = start_reg;
            `CLI_OFS_MAXT: rd_next[15:0] = maxt_reg;
            `CLI_OFS_HARM: rd_next[7:0] = harm_reg;
            `CLI_OFS_STAT: rd_next[5:0] = {state_reg, 1'b0, inrush_block,
               inrush_det, cold_load_det};
            `CLI_OFS_IRQ: rd_next[2:0] = irq_reg;
            `CLI_OFS_MASK: rd_next[2:0] = mask_reg;
            default: rerr_next = 1'b1;
         endcase
      end
   end

   // ****************************************************************
   // Detection
   // ****************************************************************
   logic all_idle, any_start, any_pick, any_harm, tick;
   logic [2:0] idle_v, start_v, harm_v;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ph
         assign idle_v[gi] = meas[gi].fund < idle_reg;
         assign start_v[gi] = meas[gi].fund > start_reg;
         // Ratio test without a divider: 100*harm > pct*fund.
         assign harm_v[gi] = (32'(meas[gi].harm) * 32'h64) >
            (32'(meas[gi].fund) * 32'(harm_reg));
      end
   endgenerate
   assign all_idle = &idle_v;
   assign any_start = |start_v;
   assign any_pick = |start_v;
   assign any_harm = (harm_reg == 8'h00) || (|harm_v);
   assign tick = tick_reg == 32'(TICK_CYCLES - 1);

   always_comb begin
      tick_next = tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      state_next = state_reg;
      win_next = win_reg;
      act_next = act_reg;
      cyc_next = cyc_reg;
      blk_next = blk_reg;
      ir_next = ir_reg;
      ev = 3'b000;
      if (!ctrl_reg[`CLI_CTRL_EN]) begin
         state_next = CLI_IDLE;
         blk_next = 1'b0;
         ir_next = 1'b0;
      end else if (meas_valid) begin
         unique case (state_reg)
            CLI_IDLE: if (all_idle) state_next = CLI_ARMED;
            CLI_ARMED: if (!all_idle) begin
               win_next = 8'h00;
               if (any_start) begin
                  state_next = CLI_ACTIVE;
               end else begin
                  state_next = CLI_WINDOW;
               end
            end
            CLI_WINDOW: if (all_idle) begin
               state_next = CLI_ARMED;
            end else if (any_start) begin
               state_next = CLI_ACTIVE;
            end
            CLI_ACTIVE: if (!any_pick) begin
               state_next = CLI_IDLE;
               blk_next = 1'b0;
               ir_next = 1'b0;
            end else if (!cyc_reg) begin
               cyc_next = 1'b1;
               ir_next = any_harm;
               blk_next = any_harm && ctrl_reg[`CLI_CTRL_BLK];
               ev[`CLI_EV_IR] = any_harm;
            end
         endcase
         if (state_next == CLI_ACTIVE && state_reg != CLI_ACTIVE) begin
            act_next = 16'h0000;
            cyc_next = 1'b0;
            ir_next = harm_reg == 8'h00;
            blk_next = ctrl_reg[`CLI_CTRL_BLK];
            ev[`CLI_EV_CL] = 1'b1;
         end
      end
      // A start seen on the last window tick still counts as in time.
      if (state_reg == CLI_WINDOW && state_next == CLI_WINDOW && tick) begin
         win_next = win_reg + 8'h01;
         if (win_reg + 8'h01 >= 8'(`CLI_WIN_MS)) begin
            state_next = CLI_IDLE;
            ev[`CLI_EV_ABORT] = 1'b1;
         end
      end
      if (state_reg == CLI_ACTIVE && tick) begin
         act_next = act_reg + 16'h0001;
         if (act_reg + 16'h0001 >= maxt_reg) begin
            state_next = CLI_IDLE;
            blk_next = 1'b0;
            ir_next = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= 2'b00;
         idle_reg <= `CLI_RST_IDLE;
         start_reg <= `CLI_RST_START;
         maxt_reg <= `CLI_RST_MAXT;
         {harm_reg, irq_reg, mask_reg} <= '0;
         {aw_reg, w_reg, awa_reg, wd_reg, ws_reg} <= '0;
         {bv_reg, berr_reg, rv_reg, rerr_reg, rd_reg} <= '0;
         state_reg <= CLI_IDLE;
         {tick_reg, win_reg, act_reg} <= '0;
         {cyc_reg, blk_reg, ir_reg} <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         {idle_reg, start_reg} <= {idle_next, start_next};
         {maxt_reg, harm_reg} <= {maxt_next, harm_next};
         {irq_reg, mask_reg} <= {irq_next, mask_next};
         {aw_reg, w_reg, awa_reg} <= {aw_next, w_next, awa_next};
         {wd_reg, ws_reg} <= {wd_next, ws_next};
         {bv_reg, berr_reg, rv_reg} <= {bv_next, berr_next, rv_next};
         {rerr_reg, rd_reg} <= {rerr_next, rd_next};
         state_reg <= state_next;
         {tick_reg, win_reg, act_reg} <= {tick_next, win_next, act_next};
         {cyc_reg, blk_reg, ir_reg} <= {cyc_next, blk_next, ir_next};
      end
   end

   assign cold_load_det = state_reg == CLI_ACTIVE;
   assign inrush_det = ir_reg;
   assign inrush_block = blk_reg;
   assign irq = |(irq_reg & mask_reg);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   arm_needs_idle_a: assert property (
      state_reg == CLI_IDLE && $past(state_reg) == CLI_IDLE
      && ctrl_reg[`CLI_CTRL_EN] && meas_valid && all_idle
      |=> state_reg == CLI_ARMED)
      else $error("idle phases did not arm");
   window_bound_a: assert property (
      state_reg == CLI_WINDOW |-> win_reg < 8'(`CLI_WIN_MS))
      else $error("window ran past limit");
   start_fires_a: assert property (
      state_reg == CLI_WINDOW && meas_valid && ctrl_reg[`CLI_CTRL_EN]
      && !all_idle && any_start |=> cold_load_det)
      else $error("start level did not fire");
   pick_drop_a: assert property (
      cold_load_det && meas_valid && !any_pick && ctrl_reg[`CLI_CTRL_EN]
      |=> !cold_load_det)
      else $error("cold load held below pickup");
   maxt_bound_a: assert property (
      cold_load_det |-> act_reg < maxt_reg)
      else $error("cold load exceeded max time");
   inrush_sub_a: assert property (
      inrush_det |-> cold_load_det)
      else $error("inrush without cold load");
   block_start_a: assert property (
      $rose(cold_load_det) && ctrl_reg[`CLI_CTRL_BLK] |-> inrush_block)
      else $error("blocking late at start");
   block_release_a: assert property (
      cold_load_det && !cyc_reg && meas_valid && any_pick && !any_harm
      && ctrl_reg[`CLI_CTRL_EN] ##1 cold_load_det |-> !inrush_block)
      else $error("blocking not released");
   zero_harm_a: assert property (
      harm_reg == 8'h00 |-> inrush_det == cold_load_det)
      else $error("zero threshold inrush differs");
   block_scope_a: assert property (
      inrush_block |-> cold_load_det)
      else $error("blocking outside cold load");
   range_a: assert property (
      idle_reg <= `CLI_IDLE_MAX && start_reg >= `CLI_START_MIN)
      else $error("threshold out of range");

   cl_cov_c: cover property ($rose(cold_load_det));
   ir_cov_c: cover property ($rose(inrush_det));
   abort_cov_c: cover property (ev[`CLI_EV_ABORT]);
   rel_cov_c: cover property ($fell(inrush_block) && cold_load_det);

endmodule : cli_detector

// >>> tb/cli_fe_model.sv
// Behavioural measurement front end that strobes phase magnitudes.
`timescale 1ns/1ps
module cli_fe_model
   import cli_pkg::*;
#(
   parameter int PERIOD = 20
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Values to send and the strobed bus.
   input wire cli_phase_t [2:0] tgt,
   output cli_phase_t [2:0] meas,
   output logic meas_valid
);
   int cnt;
   // Between strobes the bus toggles, so stale data never looks valid.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 0;
         meas_valid <= 1'b0;
         meas <= '0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         meas_valid <= (cnt == PERIOD - 1);
         meas <= (cnt == PERIOD - 1) ? tgt : ~meas;
      end
   end
endmodule : cli_fe_model

// >>> tb/cold_load_inrush_detector_bench.sv
// Self-checking bench for the cold-load and inrush detector.
`timescale 1ns/1ps
`include "cli_regs.svh"
module cold_load_inrush_detector_bench
   import cli_pkg::*;
   ;
   // ***
   // Signals and instances
   // ***
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_awaddr = '0, s_araddr = '0;
   logic [31:0] s_wdata = '0;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
   logic s_rready = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   cli_phase_t [2:0] tgt = '0;
   cli_phase_t [2:0] meas;
   logic meas_valid, cold_load_det, inrush_det, inrush_block, irq;
   int err_total = 0, comparisons = 0;
   int n;
   always #5 aclk = ~aclk;
   cli_detector #(.TICK_CYCLES(10)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .meas(meas),
      .meas_valid(meas_valid), .cold_load_det(cold_load_det),
      .inrush_det(inrush_det), .inrush_block(inrush_block), .irq(irq));
   cli_fe_model #(.PERIOD(20)) fe (.aclk(aclk), .aresetn(aresetn),
      .tgt(tgt), .meas(meas), .meas_valid(meas_valid));
   // ***
   // Helpers
   // ***
   task automatic check_word(input logic [31:0] got, exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : check_word
   task automatic check_bit(input logic got, exp, input string m);
      check_word({31'h0, got}, {31'h0, exp}, m);
   endtask : check_bit
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `CLI_RESP_OK);
      int k;
      k = 0;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         k++;
      end while (s_bvalid !== 1'b1 && k < 50);
      s_bready <= 1'b0;
      check_word({29'h0, s_bvalid, s_bresp}, {29'h0, 1'b1, er}, "wr resp");
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = `CLI_RESP_OK, input logic [31:0] msk = '1);
      int k;
      k = 0;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         k++;
      end while (s_rvalid !== 1'b1 && k < 50);
      s_rready <= 1'b0;
      check_word({29'h0, s_rvalid, s_rresp}, {29'h0, 1'b1, er}, "rd resp");
      check_word(s_rdata & msk, e, "rd data");
   endtask : rd_chk
   task automatic wrrd(input logic [7:0] a, input logic [31:0] d, e);
      wr(a, d);
      rd_chk(a, e);
   endtask : wrrd
   task automatic strobes(input int k);
      repeat (k) @(posedge aclk iff meas_valid);
      #1;
   endtask : strobes
   task automatic setp(input logic [15:0] f0, f1, f2, h0);
      @(posedge aclk);
      tgt <= {{f2, 16'h0}, {f1, 16'h0}, {f0, h0}};
   endtask : setp
   task automatic arm;
      setp(16'h10, 16'h10, 16'h10, 16'h0);
      strobes(3);
   endtask : arm
   task automatic wait_cold;
      n = 0;
      while (cold_load_det !== 1'b1 && n < 200) begin
         @(posedge aclk);
         #1;
         n++;
      end
      check_bit(cold_load_det, 1'b1, "cold load on");
   endtask : wait_cold
   // ***
   // Scenarios
   // ***
   task automatic t_regs;
      rd_chk(`CLI_OFS_CTRL, 32'h0);
      rd_chk(`CLI_OFS_IDLE, {16'h0, `CLI_RST_IDLE});
      rd_chk(`CLI_OFS_START, {16'h0, `CLI_RST_START});
      rd_chk(`CLI_OFS_MAXT, {16'h0, `CLI_RST_MAXT});
      wrrd(`CLI_OFS_IDLE, 32'h1, {16'h0, `CLI_IDLE_MIN});
      wrrd(`CLI_OFS_IDLE, 32'hFF, {16'h0, `CLI_IDLE_MAX});
      wrrd(`CLI_OFS_START, 32'h1, {16'h0, `CLI_START_MIN});
      wrrd(`CLI_OFS_START, 32'hFFFF, {16'h0, `CLI_START_MAX});
      wrrd(`CLI_OFS_MAXT, 32'h7530, {16'h0, `CLI_MAXT_MAX});
      wrrd(`CLI_OFS_HARM, 32'hFF, {24'h0, `CLI_HARM_MAX});
      wr(8'h40, 32'h3, `CLI_RESP_ERR);
      rd_chk(8'h40, 32'h0, `CLI_RESP_ERR, 32'h0);
      wrrd(`CLI_OFS_IDLE, 32'h19, 32'h19);
      wrrd(`CLI_OFS_START, 32'h100, 32'h100);
      wrrd(`CLI_OFS_MAXT, 32'h1F4, 32'h1F4);
      wrrd(`CLI_OFS_HARM, 32'h0, 32'h0);
      check_bit(irq, 1'b0, "irq idle");
      $display("test regs done");
   endtask : t_regs
   task automatic t_cold;
      wr(`CLI_OFS_CTRL, 32'h1);
      wr(`CLI_OFS_MASK, 32'h1);
      arm;
      setp(16'h10, 16'h10, 16'h200, 16'h0);
      wait_cold;
      check_bit(inrush_block, 1'b0, "block off when disabled");
      check_bit(inrush_det, 1'b1, "zero ratio inrush at start");
      rd_chk(`CLI_OFS_IRQ, 32'h1, `CLI_RESP_OK, 32'h1);
      check_bit(irq, 1'b1, "irq on cold start");
      wr(`CLI_OFS_IRQ, 32'h1);
      check_bit(irq, 1'b0, "irq cleared");
      strobes(1);
      check_bit(inrush_det, 1'b1, "zero ratio inrush");
      setp(16'h10, 16'h10, 16'h80, 16'h0);
      strobes(2);
      check_bit(cold_load_det, 1'b0, "cold ends below pickup");
      check_bit(inrush_det, 1'b0, "inrush ends with cold");
      $display("test cold done");
   endtask : t_cold
   task automatic t_noarm;
      setp(16'h10, 16'h30, 16'h10, 16'h0);
      strobes(3);
      rd_chk(`CLI_OFS_STAT, 32'h0, `CLI_RESP_OK, 32'h30);
      setp(16'h10, 16'h30, 16'h200, 16'h0);
      strobes(3);
      check_bit(cold_load_det, 1'b0, "not armed");
      $display("test noarm done");
   endtask : t_noarm
   task automatic t_window;
      wr(`CLI_OFS_MASK, 32'h4);
      arm;
      setp(16'h10, 16'h80, 16'h10, 16'h0);
      strobes(2);
      setp(16'h10, 16'h200, 16'h10, 16'h0);
      wait_cold;
      setp(16'h10, 16'h80, 16'h10, 16'h0);
      strobes(2);
      arm;
      setp(16'h10, 16'h80, 16'h10, 16'h0);
      strobes(2);
      rd_chk(`CLI_OFS_STAT, 32'h20, `CLI_RESP_OK, 32'h30);
      strobes(5);
      rd_chk(`CLI_OFS_STAT, 32'h0, `CLI_RESP_OK, 32'h30);
      check_bit(irq, 1'b1, "irq on window abort");
      setp(16'h10, 16'h200, 16'h10, 16'h0);
      strobes(2);
      check_bit(cold_load_det, 1'b0, "no late detection");
      wr(`CLI_OFS_IRQ, 32'h4);
      check_bit(irq, 1'b0, "abort irq cleared");
      $display("test window done");
   endtask : t_window
   task automatic t_maxt;
      wr(`CLI_OFS_MAXT, 32'h3);
      arm;
      setp(16'h10, 16'h10, 16'h200, 16'h0);
      wait_cold;
      n = 0;
      while (cold_load_det === 1'b1 && n < 100) begin
         @(posedge aclk);
         #1;
         n++;
      end
      check_bit(n >= 20 && n <= 40, 1'b1, "max time span");
      strobes(3);
      check_bit(cold_load_det, 1'b0, "re-arm needed");
      wr(`CLI_OFS_MAXT, 32'h1F4);
      $display("test maxt done");
   endtask : t_maxt
   task automatic t_inrush;
      wr(`CLI_OFS_CTRL, 32'h3);
      wr(`CLI_OFS_HARM, 32'hF);
      wr(`CLI_OFS_MASK, 32'h2);
      for (int i = 0; i < 2; i++) begin
         arm;
         setp(16'h200, 16'h10, 16'h10, (i == 0) ? 16'h80 : 16'h10);
         wait_cold;
         check_bit(inrush_block, 1'b1, "block at start");
         check_bit(inrush_det, 1'b0, "no ratio yet");
         strobes(1);
         check_bit(inrush_det, i == 0, "inrush by ratio");
         check_bit(inrush_block, i == 0, "block by ratio");
         rd_chk(`CLI_OFS_IRQ, (i == 0) ? 32'h2 : 32'h0, `CLI_RESP_OK, 32'h2);
         check_bit(irq, i == 0, "irq on inrush");
         setp(16'h10, 16'h10, 16'h80, 16'h0);
         strobes(2);
         check_bit(cold_load_det, 1'b0, "cold ends");
         wr(`CLI_OFS_IRQ, 32'h2);
      end
      $display("test inrush done");
   endtask : t_inrush
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_cold;
      t_noarm;
      t_window;
      t_maxt;
      t_inrush;
      tally_and_finish;
   end
   // The tests need about 12 us; eight times that means a hang.
   initial begin
      #100us;
      err_total++;
      $display("FAIL %0t watchdog expired", $time);
      tally_and_finish;
   end
endmodule : cold_load_inrush_detector_bench
